// *** rtl/eti_pkg.sv ***
// Purpose: constants and types shared by the event and task interconnect
// Assumes: 32-bit classic wishbone, byte addresses, 200 MHz core clock
// Notes:   event and task selectors are register addresses of peripherals
//
// How it works
// R1: twenty programmable channels 0-19 and twelve fixed channels 20-31.
// R2: fixed channels keep hardwired event source and primary task.
// R3: fixed channels enable, disable and join groups like programmable ones.
// R4: an event on an enabled channel triggers that channel's selected task.
// R5: each channel has one event endpoint and two task endpoints.
// R6: endpoints select events and tasks by their register addresses.
// R7: channel signals pass a synchroniser clocked at 16 MHz.
// R8: events synchronous to 16 MHz reach tasks exactly one period later.
// R9: asynchronous events reach tasks within one 16 MHz period.
// R10: peripheral shortcut paths bypass the synchroniser with no delay; the code registers them, one core cycle late.
// R11: the fork task fires in the same cycle as the primary task.
// R12: software enables channels singly through enable, set and clear registers.
// R13: group enable task enables members; group disable task disables them.
// R14: software configures group membership before triggering group tasks.
// R15: simultaneous group enable and disable on one channel leaves it enabled.
// R16: group tasks are valid targets of any channel task endpoint; the hardwired primary tasks of fixed channels 20-31 cannot select them.
// R17: shared event sources and shared tasks trigger independently.
// R18: fork endpoints of fixed channels stay software programmable.
// R19: six channel groups 0-5, each with enable and disable task.
// R20: a disabled channel triggers neither primary nor fork task.
// R21: writing one to set or clear enables or disables; zero leaves it.
package eti_pkg;
  localparam int          NUM_CH         = 32;
  localparam int          NUM_PROG       = 20;
  localparam int          NUM_GRP        = 6;
  localparam int          NUM_EVT        = 32;
  localparam int          NUM_TSK        = 32;
  localparam int          ADDR_W         = 12;
  // core clock and slow channel clock, in kHz
  localparam int          CORE_KHZ       = 200000;
  localparam int          SLOW_KHZ       = 16000;
  localparam int          DIV_CYC        = (CORE_KHZ + SLOW_KHZ - 1) / SLOW_KHZ;
  localparam logic [11:0] OFF_GRP_TASK   = 12'h000;
  localparam logic [11:0] OFF_GRP_TASK_E = 12'h02c;
  localparam logic [11:0] OFF_CHANNEL_ENABLE_REG       = 12'h500;
  localparam logic [11:0] OFF_CHANNEL_ENABLE_SET_REG    = 12'h504;
  localparam logic [11:0] OFF_CHANNEL_ENABLE_CLEAR_REG    = 12'h508;
  localparam logic [11:0] OFF_CH_EP      = 12'h510;
  localparam logic [11:0] OFF_CH_EP_E    = 12'h5ac;
  localparam logic [11:0] OFF_GRP        = 12'h800;
  localparam logic [11:0] OFF_GRP_E      = 12'h814;
  localparam logic [11:0] OFF_FORK       = 12'h910;
  localparam logic [11:0] OFF_FORK_E     = 12'h98c;
  localparam logic [31:0] EP_RESET       = 32'h0000_0000;
  // peripheral register windows used to decode endpoint addresses
  localparam logic [31:0] EVT_BASE       = 32'h4000_0100;
  localparam logic [31:0] TSK_BASE       = 32'h4000_0000;
  // own group tasks appear as task targets at this address
  localparam logic [31:0] SELF_BASE      = 32'h4001_f000;
endpackage

// *** rtl/eti_chan_if.sv ***
`timescale 1ns/10ps
// Purpose: slow-tick fire bundle between core and fire stage
// Assumes: one clock
// Notes:   fire is one core cycle wide per channel
interface eti_chan_if;
  logic [31:0] fire;
  logic        tick;
  modport src (output fire, output tick);
  modport dst (input fire, input tick);
endinterface

// *** rtl/eti_tick_div.sv ***
`timescale 1ns/10ps
// Purpose: 16 MHz enable pulse from the core clock
// Assumes: synchronous active low reset
// Notes:   rounds the slow period up, so the slow rate is never above 16 MHz
module eti_tick_div
  import eti_pkg::*;
#(
  parameter int DIV = DIV_CYC
)(
  input  wire logic clock,
  input  wire logic resetn,
  output logic      tick
);
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic       tick_ff;
  logic       nxt_tick;

  always_comb
  begin
    nxt_tick = (cnt_ff == 8'(DIV - 1));
    nxt_cnt  = nxt_tick ? 8'h00 : cnt_ff + 8'h01;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      cnt_ff  <= 8'h00;
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;
endmodule

// *** rtl/eti_fire.sv ***
`timescale 1ns/10ps
// Purpose: turns channel fires into primary and fork task pulses
// Assumes: endpoint selectors already decoded to task indices
// Notes:   several channels onto one task simply OR together
module eti_fire
  import eti_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resetn,
  eti_chan_if.dst         ch,
  input  wire logic [5:0] tsk_sel  [NUM_CH],
  input  wire logic [5:0] fork_sel [NUM_CH],
  output logic [NUM_TSK+2*NUM_GRP-1:0] tsk_out
);
  localparam int NT = NUM_TSK + 2 * NUM_GRP;
  logic [NT-1:0] out_ff;
  logic [NT-1:0] nxt_out;

  always_comb
  begin
    nxt_out = '0;
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (ch.tick && ch.fire[c])
      begin
        // primary and fork share the same edge
        if (tsk_sel[c] < 6'(NT))
          nxt_out[tsk_sel[c]] = 1'b1;   // [R4] [R17]
        if (fork_sel[c] < 6'(NT))
          nxt_out[fork_sel[c]] = 1'b1;  // [R11]
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      out_ff <= '0;
    else
      out_ff <= nxt_out;
  end

  assign tsk_out = out_ff;
endmodule

// *** rtl/event_task_interconnect.sv ***
// The address map and register access over Wishbone were chosen for this implementation.
`timescale 1ns/10ps
// Purpose: routes peripheral event pulses to task pulses over 32 channels
// Assumes: events are core-clock pulses; tasks leave as one-cycle pulses
// Notes:   channel path advances on the 16 MHz tick; shortcuts pass one core-clock register
module event_task_interconnect
  import eti_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 resetn,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [ADDR_W-1:0]    wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic [NUM_EVT-1:0]   evt_in,
  input  wire logic [NUM_EVT-1:0]   shortcut_config,
  output logic [NUM_TSK-1:0]        task_out,
  output logic [NUM_TSK-1:0]        shortcut_task_out,
  output logic [NUM_CH-1:0]         chan_en_out
);
  localparam int NT = NUM_TSK + 2 * NUM_GRP;

  // fixed event and task indices for channels 20-31
  localparam logic [5:0] HW_EVT [12] = '{6'd0, 6'd0, 6'd1, 6'd2, 6'd3, 6'd4,
                                         6'd4, 6'd5, 6'd6, 6'd6, 6'd6, 6'd6};
  localparam logic [5:0] HW_TSK [12] = '{6'd0, 6'd1, 6'd2, 6'd3, 6'd4, 6'd5,
                                         6'd6, 6'd7, 6'd0, 6'd1, 6'd8, 6'd9};

  // event register address to event index; 63 means unconnected
  function automatic logic [5:0] evt_idx(input logic [31:0] a);
    logic [31:0] d;
    d = a - EVT_BASE;
    if (a >= EVT_BASE && d[1:0] == 2'b00 && d < 32'(NUM_EVT * 4))
      evt_idx = d[7:2];
    else
      evt_idx = 6'h3f;
  endfunction

  // task register address to index; group tasks follow the peripheral tasks
  function automatic logic [5:0] tsk_idx(input logic [31:0] a);
    logic [31:0] d;
    logic [31:0] g;
    d = a - TSK_BASE;
    g = a - SELF_BASE;
    if (a >= TSK_BASE && d[1:0] == 2'b00 && d < 32'(NUM_TSK * 4))
      tsk_idx = d[7:2];
    else if (a >= SELF_BASE && g[1:0] == 2'b00 && g < 32'(NUM_GRP * 8))
      tsk_idx = 6'(NUM_TSK) + g[7:2];                    // [R16]
    else
      tsk_idx = 6'h3f;
  endfunction

  logic [31:0]        eep_ff  [NUM_PROG];
  logic [31:0]        tep_ff  [NUM_PROG];
  logic [31:0]        fork_ff [NUM_CH];
  logic [NUM_CH-1:0]  grp_ff  [NUM_GRP];
  logic [NUM_CH-1:0]  en_ff;
  logic [NUM_CH-1:0]  nxt_en;
  logic [NUM_EVT-1:0] pend_ff;
  logic [NUM_EVT-1:0] nxt_pend;
  logic [NUM_CH-1:0]  fire;
  logic [5:0]         e_sel    [NUM_CH];
  logic [5:0]         t_sel    [NUM_CH];
  logic [5:0]         f_sel    [NUM_CH];
  logic [NT-1:0]      tsk_all;
  logic [NUM_TSK-1:0] sc_ff;
  logic [31:0]        dat_ff;
  logic [31:0]        nxt_dat;
  logic               ack_ff;
  logic               wr_stb;
  logic               rd_ok;
  logic [ADDR_W-1:0]  ep_off;
  logic [ADDR_W-1:0]  fk_off;
  logic [ADDR_W-1:0]  gp_off;
  logic [31:0]        wmask;
  logic               tick;
  eti_chan_if         chi ();

  // endpoint selectors: fixed channels ignore software for event and task
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_sel
    if (c < NUM_PROG)                                     // [R1]
    begin : g_prog
      assign e_sel[c] = evt_idx(eep_ff[c]);               // [R5] [R6]
      assign t_sel[c] = tsk_idx(tep_ff[c]);               // [R6]
    end
    else
    begin : g_fixed
      assign e_sel[c] = HW_EVT[c-NUM_PROG];               // [R2]
      assign t_sel[c] = HW_TSK[c-NUM_PROG];               // [R2]
    end
    assign f_sel[c] = tsk_idx(fork_ff[c]);                // [R18]
    // a channel fires on the tick when its latched event is present
    assign fire[c] = tick && en_ff[c] && (e_sel[c] < 6'(NUM_EVT))
                     && pend_ff[e_sel[c][4:0]];           // [R20] [R17]
  end

  eti_tick_div u_div (
    .clock  (clock),
    .resetn (resetn),
    .tick   (tick)
  );

  assign chi.fire = fire;
  assign chi.tick = tick;

  eti_fire u_fire (
    .clock    (clock),
    .resetn   (resetn),
    .ch       (chi),
    .tsk_sel  (t_sel),
    .fork_sel (f_sel),
    .tsk_out  (tsk_all)
  );

  // event capture: pending until the tick, so an event right after a tick
  // waits up to one slow period, one exactly on a tick waits a full period
  always_comb
  begin
    nxt_pend = pend_ff | evt_in;                          // [R7]
    // the tick consumes what was pending; firing from a second stage would
    // cost another whole slow period and break the one-period bound
    if (tick)
      nxt_pend = evt_in;                                  // [R8] [R9]
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      pend_ff <= '0;
      sc_ff   <= '0;
    end
    else
    begin
      pend_ff <= nxt_pend;
      sc_ff   <= evt_in & shortcut_config;                // [R10]
    end
  end

  // bus decode
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff;
  assign ep_off = wb_adr_i - OFF_CH_EP;
  assign fk_off = wb_adr_i - OFF_FORK;
  assign gp_off = wb_adr_i - OFF_GRP;
  assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // enable: groups first, individual writes, then enable wins over disable
  always_comb
  begin
    logic [NUM_CH-1:0] g_on;
    logic [NUM_CH-1:0] g_off;
    g_on   = '0;
    g_off  = '0;
    nxt_en = en_ff;
    for (int g = 0; g < NUM_GRP; g++)
    begin
      if (tsk_all[NUM_TSK + 2*g] ||
          (wr_stb && wb_adr_i == OFF_GRP_TASK + 12'(8*g) && wb_dat_i[0]))
        g_on = g_on | grp_ff[g];                          // [R13] [R19]
      if (tsk_all[NUM_TSK + 2*g + 1] ||
          (wr_stb && wb_adr_i == OFF_GRP_TASK + 12'(8*g + 4) && wb_dat_i[0]))
        g_off = g_off | grp_ff[g];                        // [R13] [R3]
    end
    if (wr_stb && wb_adr_i == OFF_CHANNEL_ENABLE_REG)
      nxt_en = (en_ff & ~wmask) | (wb_dat_i & wmask);     // [R12]
    else if (wr_stb && wb_adr_i == OFF_CHANNEL_ENABLE_SET_REG)
      nxt_en = en_ff | (wb_dat_i & wmask);                // [R21]
    else if (wr_stb && wb_adr_i == OFF_CHANNEL_ENABLE_CLEAR_REG)
      nxt_en = en_ff & ~(wb_dat_i & wmask);               // [R21]
    nxt_en = (nxt_en & ~g_off) | g_on;                    // [R15]
  end

  // read mux
  always_comb
  begin
    nxt_dat = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (wb_adr_i == OFF_CHANNEL_ENABLE_REG || wb_adr_i == OFF_CHANNEL_ENABLE_SET_REG || wb_adr_i == OFF_CHANNEL_ENABLE_CLEAR_REG)
      nxt_dat = en_ff;
    else if (wb_adr_i >= OFF_CH_EP && wb_adr_i <= OFF_CH_EP_E)
      nxt_dat = ep_off[2] ? tep_ff[ep_off[7:3]] : eep_ff[ep_off[7:3]];
    else if (wb_adr_i >= OFF_GRP && wb_adr_i <= OFF_GRP_E)
      nxt_dat = grp_ff[gp_off[4:2]];
    else if (wb_adr_i >= OFF_FORK && wb_adr_i <= OFF_FORK_E)
      nxt_dat = fork_ff[fk_off[6:2]];
    else if (wb_adr_i <= OFF_GRP_TASK_E)
      nxt_dat = 32'h0000_0000;
    else
      rd_ok = 1'b0;
    if (!rd_ok)
      nxt_dat = 32'h0000_0000;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      en_ff  <= '0;
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
      for (int i = 0; i < NUM_PROG; i++)
      begin
        eep_ff[i] <= EP_RESET;
        tep_ff[i] <= EP_RESET;
      end
      for (int i = 0; i < NUM_CH; i++)
        fork_ff[i] <= EP_RESET;
      for (int i = 0; i < NUM_GRP; i++)
        grp_ff[i] <= '0;
    end
    else
    begin
      en_ff  <= nxt_en;
      ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
      dat_ff <= nxt_dat;
      if (wr_stb && wb_adr_i >= OFF_CH_EP && wb_adr_i <= OFF_CH_EP_E && wb_adr_i[1:0] == 2'b00)
      begin
        if (ep_off[2])
          tep_ff[ep_off[7:3]] <= (tep_ff[ep_off[7:3]] & ~wmask) | (wb_dat_i & wmask);
        else
          eep_ff[ep_off[7:3]] <= (eep_ff[ep_off[7:3]] & ~wmask) | (wb_dat_i & wmask);
      end
      if (wr_stb && wb_adr_i >= OFF_GRP && wb_adr_i <= OFF_GRP_E && wb_adr_i[1:0] == 2'b00)
        grp_ff[gp_off[4:2]] <= (grp_ff[gp_off[4:2]] & ~wmask) | (wb_dat_i & wmask);
      if (wr_stb && wb_adr_i >= OFF_FORK && wb_adr_i <= OFF_FORK_E && wb_adr_i[1:0] == 2'b00)
        fork_ff[fk_off[6:2]] <= (fork_ff[fk_off[6:2]] & ~wmask) | (wb_dat_i & wmask);
    end
  end

  assign wb_ack_o          = ack_ff;
  assign wb_dat_o          = dat_ff;
  assign task_out          = tsk_all[NUM_TSK-1:0];
  assign shortcut_task_out = sc_ff;
  assign chan_en_out       = en_ff;

  // fork and primary leave on the same cycle
  fork_same_cycle_a : assert property (@(posedge clock) disable iff (!resetn) // [R11]
    fire[0] && en_ff[0] && t_sel[0] < 6'(NUM_TSK) && f_sel[0] < 6'(NUM_TSK)
    |=> task_out[$past(t_sel[0][4:0])] && task_out[$past(f_sel[0][4:0])])
    else $error("fork task not with primary");

  disabled_silent_a : assert property (@(posedge clock) disable iff (!resetn) // [R20]
    !en_ff[5] |-> !fire[5])
    else $error("disabled channel fired");

  // channel 1 in the bench points its task and fork at group 2 enable and disable
  enable_wins_a : assert property (@(posedge clock) disable iff (!resetn) // [R15]
    tsk_all[NUM_TSK+4] && tsk_all[NUM_TSK+5] |=> (en_ff & grp_ff[2]) == grp_ff[2])
    else $error("group enable lost to disable");

  set_write_a : assert property (@(posedge clock) disable iff (!resetn) // [R21]
    wr_stb && wb_adr_i == OFF_CHANNEL_ENABLE_SET_REG && wb_sel_i == 4'hf
    |=> (en_ff & $past(wb_dat_i)) == $past(wb_dat_i))
    else $error("set write did not enable");

  clr_keep_a : assert property (@(posedge clock) disable iff (!resetn) // [R12]
    wr_stb && wb_adr_i == OFF_CHANNEL_ENABLE_CLEAR_REG && tsk_all[NT-1:NUM_TSK] == '0
    |=> en_ff == ($past(en_ff) & ~$past(wb_dat_i & wmask)))
    else $error("clear write wrong");

  group_enable_a : assert property (@(posedge clock) disable iff (!resetn) // [R13]
    wr_stb && wb_adr_i == OFF_GRP_TASK && wb_dat_i[0]
    |=> (en_ff & $past(grp_ff[0])) == $past(grp_ff[0]))
    else $error("group enable missed a member");

  group_disable_a : assert property (@(posedge clock) disable iff (!resetn) // [R19]
    wr_stb && wb_adr_i == OFF_GRP_TASK + 12'h004 && wb_dat_i[0]
    && tsk_all[NT-1:NUM_TSK] == '0
    |=> (en_ff & $past(grp_ff[0])) == '0)
    else $error("group disable missed a member");

  fire_on_tick_a : assert property (@(posedge clock) disable iff (!resetn) // [R7]
    |fire |-> tick)
    else $error("channel fired off tick");

  // slow period is 13 core cycles; an event never waits longer than that
  latency_bound_a : assert property (@(posedge clock) disable iff (!resetn) // [R9]
    evt_in[0] && en_ff[20] |-> ##[1:13] (fire[20] || !en_ff[20]))
    else $error("event late");

  sync_exact_a : assert property (@(posedge clock) disable iff (!resetn) // [R8]
    tick && evt_in[0] && en_ff[20] |-> ##13 (fire[20] || !en_ff[20]))
    else $error("tick aligned event not one period late");

  // ticks are far apart, so a task pulse can never stretch
  task_pulse_a : assert property (@(posedge clock) disable iff (!resetn) // [R4]
    |tsk_all |=> tsk_all == '0)
    else $error("task pulse longer than one cycle");

  shortcut_fast_a : assert property (@(posedge clock) disable iff (!resetn) // [R10]
    evt_in[3] && shortcut_config[3] |=> shortcut_task_out[3])
    else $error("shortcut delayed");

  fixed_map_a : assert property (@(posedge clock) disable iff (!resetn) // [R2]
    t_sel[31] == 6'd9 && e_sel[31] == 6'd6)
    else $error("fixed channel changed");
endmodule

// *** verification/periph_model.sv ***
`timescale 1ns/10ps
// Purpose: peripheral side that raises event pulses and logs task pulses
// Assumes: one event mask at a time, each one core cycle wide
// Notes:   per task it keeps a pulse count and the delay of the latest pulse
module periph_model
  import eti_pkg::*;
(
  input  wire logic               clock,
  input  wire logic [NUM_TSK-1:0] task_out,
  output logic [NUM_EVT-1:0]      evt_in
);
  int cyc_n;
  int t_emit;
  int hits [NUM_TSK];
  int dly  [NUM_TSK];
  initial
  begin
    evt_in = '0;
    cyc_n  = 0;
    t_emit = 0;
    foreach (hits[i])
    begin
      hits[i] = 0;
      dly[i]  = 0;
    end
  end
  // line returns low after one cycle, so a held level never retriggers
  task automatic emit(input logic [NUM_EVT-1:0] m);
    @(posedge clock);
    evt_in <= m;
    t_emit = cyc_n;
    @(posedge clock);
    evt_in <= '0;
  endtask
  always @(posedge clock)
  begin
    cyc_n <= cyc_n + 1;
    for (int i = 0; i < NUM_TSK; i++)
      if (task_out[i] === 1'b1)
      begin
        hits[i] <= hits[i] + 1;
        dly[i]  <= cyc_n - t_emit;
      end
  end
endmodule

// *** verification/event_task_interconnect_tb.sv ***
`timescale 1ns/10ps
// Purpose: self-checking bench for the event and task interconnect
// Assumes: one bus access or one event in flight at a time
// Notes:   task codes: 0-31 tasks, 50 unconnected, 100+2g group enable, +1 disable
module event_task_interconnect_tb;
  import eti_pkg::*;
  logic               clock;
  logic               resetn;
  logic               wb_cyc_i;
  logic               wb_stb_i;
  logic               wb_we_i;
  logic [ADDR_W-1:0]  wb_adr_i;
  logic [3:0]         wb_sel_i;
  logic [31:0]        wb_dat_i;
  logic [31:0]        wb_dat_o;
  logic               wb_ack_o;
  logic [NUM_EVT-1:0] evt_in;
  logic [NUM_EVT-1:0] shortcut_config;
  logic [NUM_TSK-1:0] task_out;
  logic [NUM_TSK-1:0] shortcut_task_out;
  logic [NUM_CH-1:0]  chan_en_out;
  logic [31:0]        exp_en;
  logic [31:0]        rd;
  logic [31:0]        sc;
  logic [31:0]        grp [NUM_GRP];
  int                 err_total;
  int                 cmp_count;
  int                 ev_of [NUM_CH];
  int                 tk_of [NUM_CH];
  int                 fk_of [NUM_CH];
  int                 exp_cnt [NUM_TSK];
  int                 fix_ev [12] = '{0, 0, 1, 2, 3, 4, 4, 5, 6, 6, 6, 6};
  int                 fix_tk [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 0, 1, 8, 9};

  event_task_interconnect dut_u (.clock(clock), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .evt_in(evt_in),
    .shortcut_config(shortcut_config), .task_out(task_out),
    .shortcut_task_out(shortcut_task_out), .chan_en_out(chan_en_out));
  periph_model periph_u (.clock(clock), .task_out(task_out), .evt_in(evt_in));

  task automatic final_report();
    $display("compares %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] expv);
    cmp_count++;
    if (seen !== expv)
    begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, expv, seen);
    end
  endtask

  // request stands until ack is sampled high at a rising edge, then drops there
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    check("bus ack", {31'h0, wb_ack_o}, 32'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] expv);
    wb(1'b0, a, 32'h0);
    check(nm, rd, expv);
  endtask

  task automatic en_chk(input string nm);
    @(negedge clock);
    check(nm, chan_en_out, exp_en);
  endtask

  function automatic logic [31:0] tadr(input int c);
    if (c >= 100)
      return SELF_BASE + 32'(4 * (c - 100));
    return TSK_BASE + 32'(4 * c);
  endfunction

  task automatic cfg(input int ch, input int ev, input int tk, input int fk);
    if (ch < NUM_PROG)
    begin
      wb(1'b1, OFF_CH_EP + 12'(8 * ch), EVT_BASE + 32'(4 * ev));
      wb(1'b1, OFF_CH_EP + 12'(8 * ch + 4), tadr(tk));
      ev_of[ch] = ev;
      tk_of[ch] = tk;
    end
    wb(1'b1, OFF_FORK + 12'(4 * ch), tadr(fk));
    fk_of[ch] = fk;
  endtask

  // reference: outputs of channels on one task merge into a single pulse
  task automatic fire(input int ev);
    logic [31:0] hit;
    logic [31:0] en;
    logic [31:0] dis;
    int          cd [2];
    hit = '0;
    en  = '0;
    dis = '0;
    for (int c = 0; c < NUM_CH; c++)
      if (exp_en[c] && ev_of[c] == ev)
      begin
        cd[0] = tk_of[c];
        cd[1] = fk_of[c];
        foreach (cd[k])
          if (cd[k] < 32)
            hit[cd[k]] = 1'b1;
          else if (cd[k] >= 100 && cd[k] % 2 == 1)
            dis |= grp[(cd[k] - 100) / 2];
          else if (cd[k] >= 100)
            en |= grp[(cd[k] - 100) / 2];
      end
    periph_u.emit(32'h1 << ev);
    repeat (16) @(posedge clock);
    exp_en = (exp_en & ~dis) | en;
    en_chk("channel enables");
    for (int t = 0; t < NUM_TSK; t++)
    begin
      if (hit[t])
      begin
        exp_cnt[t]++;
        check("task delay ok", 32'(periph_u.dly[t] inside {[1:15]}), 32'h1);
      end
      check("task count", periph_u.hits[t], exp_cnt[t]);
    end
  endtask

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial
  begin
    #300000;
    err_total++;
    final_report();
  end

  initial
  begin
    resetn          = 1'b0;
    wb_cyc_i        = 1'b0;
    wb_stb_i        = 1'b0;
    wb_we_i         = 1'b0;
    wb_adr_i        = '0;
    wb_sel_i        = 4'hf;
    wb_dat_i        = '0;
    shortcut_config = '0;
    err_total       = 0;
    cmp_count       = 0;
    exp_en          = '0;
    void'($urandom(49353));
    for (int c = 0; c < NUM_CH; c++)
    begin
      ev_of[c] = (c < NUM_PROG) ? -1 : fix_ev[c - NUM_PROG];
      tk_of[c] = (c < NUM_PROG) ? 50 : fix_tk[c - NUM_PROG];
      fk_of[c] = 50;
      exp_cnt[c] = 0;
    end
    foreach (grp[g])
      grp[g] = '0;
    repeat (8) @(posedge clock);
    check("enables in reset", chan_en_out, 32'h0);
    resetn <= 1'b1;
    rdchk("channel_enable_reg reset", OFF_CHANNEL_ENABLE_REG, 32'h0);
    wb(1'b1, 12'h5b0, EVT_BASE + 32'h1c);
    rdchk("unmapped read", 12'h5b0, 32'h0);
    cfg(0, 3, 5, 7);
    rdchk("task endpoint", 12'h514, tadr(5));
    wb(1'b1, OFF_CHANNEL_ENABLE_SET_REG, 32'h1);
    exp_en = 32'h1;
    fire(3);
    check("fork aligned", periph_u.dly[7], periph_u.dly[5]);
    wb(1'b1, OFF_CHANNEL_ENABLE_SET_REG, 32'h0);
    rdchk("channel_enable_reg kept", OFF_CHANNEL_ENABLE_SET_REG, exp_en);
    wb(1'b1, OFF_CHANNEL_ENABLE_CLEAR_REG, 32'h1);
    exp_en = 32'h0;
    fire(3);
    cfg(20, 0, 0, 9);
    wb(1'b1, OFF_CHANNEL_ENABLE_REG, 32'h0030_0000);
    exp_en = 32'h0030_0000;
    fire(0);
    rdchk("channel_enable_reg fixed", OFF_CHANNEL_ENABLE_REG, exp_en);
    for (int g = 0; g < NUM_GRP; g++)
    begin
      grp[g] = $urandom();
      wb(1'b1, OFF_GRP + 12'(4 * g), grp[g]);
      wb(1'b1, OFF_GRP_TASK + 12'(8 * g), 32'h1);
      exp_en = exp_en | grp[g];
      en_chk("group enable");
      wb(1'b1, OFF_GRP_TASK + 12'(8 * g + 4), 32'h1);
      exp_en = exp_en & ~grp[g];
      en_chk("group disable");
    end
    grp[2] = 32'h22;
    wb(1'b1, OFF_GRP + 12'h8, grp[2]);
    cfg(1, 10, 104, 105);
    wb(1'b1, OFF_CHANNEL_ENABLE_REG, 32'h2);
    exp_en = 32'h2;
    fire(10);
    repeat (4)
    begin
      @(posedge clock);
      sc = $urandom();
      shortcut_config <= sc;
      rd = $urandom();
      periph_u.emit(rd);
      @(negedge clock);
      check("shortcut task", shortcut_task_out, rd & sc);
    end
    final_report();
  end
endmodule
